/* File: coef_pkg.sv */
//****************************************************************
// Shared constants and types of the coefficient read service
//****************************************************************
package coef_pkg;

    // Frame bytes
    localparam logic [7:0] fn_read_coef = 8'h1E;       // Read-coefficient function, 30
    localparam logic [7:0] transparent_id = 8'hFA;     // Transparent node id, 250
    localparam logic [7:0] exc_flag = 8'h80;           // Marks a function code as an exception
    localparam logic [7:0] exc_range = 8'h02;          // Number above the variant maximum
    localparam logic [7:0] exc_length = 8'h03;         // Wrong request length
    localparam logic [7:0] exc_uninit = 8'h20;         // Not initialised since power-up, 32
    localparam logic [7:0] req_len = 8'h05;            // Id, function, number, two CRC bytes
    localparam logic [7:0] min_frame = 8'h04;          // Shortest frame with a checkable CRC
    localparam logic [7:0] cnt_max = 8'hFF;            // Byte counter saturates here
    localparam logic [2:0] hdr_bytes = 3'h3;           // Id, function and number are kept
    localparam logic [2:0] len_value = 3'h6;           // Reply bytes before CRC, value reply
    localparam logic [2:0] len_exc = 3'h3;             // Reply bytes before CRC, exception

    // Highest coefficient number of each product variant
    localparam logic [7:0] max_coef_v0 = 8'h6F;        // 111
    localparam logic [7:0] max_coef_v1 = 8'h7F;        // 127
    localparam logic [7:0] max_coef_v2 = 8'h9C;        // 156
    localparam int coef_depth = 157;                   // Table covers numbers 0 to 156

    // Coefficient numbers
    localparam logic [7:0] num_sqrt_thr = 8'h35;       // 53
    localparam logic [7:0] num_p1_off = 8'h40;         // 64
    localparam logic [7:0] num_p1_gain = 8'h41;        // 65
    localparam logic [7:0] num_p2_off = 8'h42;         // 66
    localparam logic [7:0] num_p2_gain = 8'h43;        // 67
    localparam logic [7:0] num_aout_off = 8'h44;       // 68
    localparam logic [7:0] num_aout_gain = 8'h45;      // 69
    localparam logic [7:0] num_ch0_off = 8'h46;        // 70
    localparam logic [7:0] num_ch0_gain = 8'h47;       // 71
    localparam logic [7:0] num_t_off = 8'h48;          // 72
    localparam logic [7:0] num_sw1_lo = 8'h49;         // 73
    localparam logic [7:0] num_sensor_one_temperature_off = 8'h4A;       // 74
    localparam logic [7:0] num_sensor_two_temperature_off = 8'h4C;       // 76
    localparam logic [7:0] num_sw2_hi = 8'h4E;         // 78
    localparam logic [7:0] num_sw2_lo = 8'h4F;         // 79
    localparam logic [7:0] num_info_lo = 8'h50;        // 80, first limit
    localparam logic [7:0] num_sig_min = 8'h5E;        // 94
    localparam logic [7:0] num_sig_max = 8'h5F;        // 95
    localparam logic [7:0] num_cal_date = 8'h63;       // 99
    localparam logic [7:0] num_cust_lo = 8'h64;        // 100
    localparam logic [7:0] num_cust_hi = 8'h6F;        // 111
    localparam logic [7:0] num_cond_lo = 8'h79;        // 121
    localparam logic [7:0] num_cond_hi = 8'h7C;        // 124
    localparam logic [7:0] num_cond_tc = 8'h7E;        // 126
    localparam logic [7:0] num_cell = 8'h7F;           // 127
    localparam logic [7:0] num_fit_lo = 8'h8C;         // 140
    localparam logic [7:0] num_fit_hi = 8'h9C;         // 156

    // Single-precision values
    localparam logic [31:0] f_zero = 32'h00000000;     // 0.0
    localparam logic [31:0] f_one = 32'h3F800000;      // 1.0
    localparam logic [31:0] f_cond_tc = 32'h3CB43958;  // 0.022
    localparam logic [31:0] f_ma_min = 32'h40800000;   // 4.0 mA
    localparam logic [31:0] f_ma_max = 32'h41A00000;   // 20.0 mA
    localparam logic [31:0] f_v_min = 32'h00000000;    // 0.0 V
    localparam logic [31:0] f_v_max = 32'h41200000;    // 10.0 V

    // CRC16, reflected polynomial
    localparam logic [15:0] crc_init = 16'hFFFF;
    localparam logic [15:0] crc_poly = 16'hA001;

    // Product variant selects the highest readable number
    typedef enum logic [1:0] {
        variant_v0 = 2'b00,
        variant_v1 = 2'b01,
        variant_v2 = 2'b10
    } variant_t;

    // Reply sequencer
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_eval = 2'b01,
        st_send = 2'b10
    } tx_state_t;

    // One byte with its strobe
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_t;

    // One coefficient write
    typedef struct packed {
        logic valid;
        logic [7:0] num;
        logic [31:0] value;
    } coef_wr_t;

    // Scaling coefficients handed to the measurement path
    typedef struct packed {
        logic [31:0] p1_offset;
        logic [31:0] p1_gain;
        logic [31:0] p2_offset;
        logic [31:0] p2_gain;
        logic [31:0] ch0_offset;
        logic [31:0] ch0_gain;
        logic [31:0] aout_offset;
        logic [31:0] aout_gain;
        logic [31:0] t_offset;
        logic [31:0] sensor_one_temperature_offset;
        logic [31:0] sensor_two_temperature_offset;
        logic [31:0] sqrt_threshold;
    } scale_t;

endpackage

/* File: crc16_byte.sv */
`timescale 1ns/1ps
//****************************************************************
// CRC16 update over one byte, least significant bit first
//****************************************************************
module crc16_byte (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);
    import coef_pkg::*;

    // Eight shift steps unrolled by the loop
    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (c[0]) begin
                c = (c >> 1) ^ crc_poly;
            end else begin
                c = c >> 1;
            end
        end
        crc_out = c;
    end
endmodule

/* File: coefficient_read_service.sv */
`timescale 1ns/1ps
module coefficient_read_service #(
    parameter coef_pkg::variant_t variant = coef_pkg::variant_v2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] bus_node_id,
    input coef_pkg::byte_t rx_byte,
    input wire logic rx_frame_end,
    input wire logic tx_ready,
    input wire logic init_ack,
    input coef_pkg::coef_wr_t host_wr,
    input coef_pkg::coef_wr_t factory_wr,
    input wire logic analog_is_current,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic initialised,
    output coef_pkg::scale_t scale
);
    import coef_pkg::*;

    //****************************************************************
    // Decode helpers
    //****************************************************************

    // Numbers the master may overwrite
    function automatic logic is_calibration(input logic [7:0] n);
        is_calibration = (n == num_sqrt_thr) ||
                         (n >= num_p1_off && n <= num_sw2_lo) ||
                         (n >= num_cust_lo && n <= num_cust_hi) ||
                         (n >= num_cond_lo && n <= num_cond_hi) ||
                         (n == num_cond_tc) || (n == num_cell) ||
                         (n >= num_fit_lo && n <= num_fit_hi);
    endfunction

    // Highest number this variant answers
    function automatic logic [7:0] max_number(input variant_t v);
        case (v)
            variant_v0: max_number = max_coef_v0;
            variant_v1: max_number = max_coef_v1;
            default: max_number = max_coef_v2;
        endcase
    endfunction

    //****************************************************************
    // State
    //****************************************************************

    logic [31:0] coef_mem [coef_depth];  // Coefficient table
    logic init_r;                        // Initialise seen since reset
    logic [7:0] hdr_r [3];               // Id, function, number
    logic [7:0] rx_cnt_r;                // Bytes of the current frame
    logic [7:0] last1_r;                 // Last byte received
    logic [7:0] last2_r;                 // Byte before it
    logic [15:0] rx_crc_r;               // CRC over all bytes so far
    logic [15:0] rx_crc_d1_r;            // CRC one byte earlier
    logic [15:0] rx_crc_d2_r;            // CRC two bytes earlier, covers payload
    tx_state_t state_r;                  // Reply sequencer
    logic [7:0] resp_r [6];              // Reply payload
    logic [2:0] resp_len_r;              // Payload length
    logic [2:0] idx_r;                   // Byte now on tx_data
    logic [15:0] tx_crc_r;               // CRC of bytes already sent
    logic tx_valid_r;
    logic [7:0] tx_data_r;
    scale_t scale_r;
    logic [15:0] rx_crc_nxt;
    logic [15:0] tx_crc_nxt;

    // Two CRC engines, one for each direction
    crc16_byte rx_crc_unit (
        .crc_in(rx_crc_r),
        .data(rx_byte.data),
        .crc_out(rx_crc_nxt)
    );
    crc16_byte tx_crc_unit (
        .crc_in(tx_crc_r),
        .data(tx_data_r),
        .crc_out(tx_crc_nxt)
    );

    // Frame checks, valid in st_eval
    logic [7:0] req_num;
    logic crc_ok;
    logic addr_ok;
    logic [31:0] read_value;
    assign req_num = hdr_r[2];
    assign crc_ok = (rx_cnt_r >= min_frame) && ({last2_r, last1_r} == rx_crc_d2_r);
    assign addr_ok = (hdr_r[0] == bus_node_id) || (hdr_r[0] == transparent_id);

    // Signal limits follow the output type; the table entry is not touched
    always_comb begin
        if (req_num == num_sig_min) begin
            read_value = analog_is_current ? f_ma_min : f_v_min;
        end else if (req_num == num_sig_max) begin
            read_value = analog_is_current ? f_ma_max : f_v_max;
        end else if (req_num < 8'(coef_depth)) begin
            read_value = coef_mem[req_num];
        end else begin
            read_value = f_zero;
        end
    end

    //****************************************************************
    // Initialisation flag
    //****************************************************************

    // Cleared only by reset, which stands for power-up; acknowledge sets it
    always_ff @(posedge clock) begin
        if (!rstn) begin
            init_r <= 1'b0;
        end else if (init_ack) begin
            init_r <= 1'b1;
        end
    end

    //****************************************************************
    // Coefficient table
    //****************************************************************

    // Factory port loads anything, the master only calibration numbers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < coef_depth; i++) begin
                coef_mem[i] <= f_zero;
            end
            coef_mem[num_p1_gain] <= f_one;
            coef_mem[num_p2_gain] <= f_one;
            coef_mem[num_ch0_gain] <= f_one;
            coef_mem[num_cond_tc] <= f_cond_tc;
            coef_mem[num_cell] <= f_one;
        end else if (factory_wr.valid && factory_wr.num < 8'(coef_depth)) begin
            // Limits, date and analogue references come from here
            coef_mem[factory_wr.num] <= factory_wr.value;
        end else if (host_wr.valid && is_calibration(host_wr.num)) begin
            // Offsets, gains, customer and conductivity words
            coef_mem[host_wr.num] <= host_wr.value;
        end
    end

    //****************************************************************
    // Receive capture
    //****************************************************************

    // Bytes arriving while a reply is pending are dropped: the link is half duplex
    always_ff @(posedge clock) begin
        if (!rstn || (state_r == st_eval)) begin
            rx_cnt_r <= 8'h00;
            last1_r <= 8'h00;
            last2_r <= 8'h00;
            rx_crc_r <= crc_init;
            rx_crc_d1_r <= crc_init;
            rx_crc_d2_r <= crc_init;
            for (int i = 0; i < 3; i++) begin
                hdr_r[i] <= 8'h00;
            end
        end else if (state_r == st_idle && rx_byte.valid) begin
            if (rx_cnt_r != cnt_max) begin
                rx_cnt_r <= rx_cnt_r + 8'h01;
            end
            if (rx_cnt_r < 8'(hdr_bytes)) begin
                hdr_r[rx_cnt_r[1:0]] <= rx_byte.data;
            end
            last1_r <= rx_byte.data;
            last2_r <= last1_r;
            rx_crc_r <= rx_crc_nxt;
            rx_crc_d1_r <= rx_crc_r;
            rx_crc_d2_r <= rx_crc_d1_r;
        end
    end

    //****************************************************************
    // Evaluation and reply sequencer
    //****************************************************************

    // Exception order: uninitialised, then length, then number range
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= st_idle;
            resp_len_r <= 3'h0;
            idx_r <= 3'h0;
            tx_crc_r <= crc_init;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            for (int i = 0; i < 6; i++) begin
                resp_r[i] <= 8'h00;
            end
        end else begin
            case (state_r)
                st_idle: begin
                    // Frame boundary from the line layer
                    if (rx_frame_end) begin
                        state_r <= st_eval;
                    end
                end
                st_eval: begin
                    if (crc_ok && addr_ok && hdr_r[1] == fn_read_coef) begin
                        resp_r[0] <= bus_node_id;
                        tx_data_r <= bus_node_id;
                        tx_valid_r <= 1'b1;
                        tx_crc_r <= crc_init;
                        idx_r <= 3'h0;
                        state_r <= st_send;
                        if (!init_r) begin
                            resp_r[1] <= fn_read_coef | exc_flag;
                            resp_r[2] <= exc_uninit;
                            resp_len_r <= len_exc;
                        end else if (rx_cnt_r != req_len) begin
                            resp_r[1] <= fn_read_coef | exc_flag;
                            resp_r[2] <= exc_length;
                            resp_len_r <= len_exc;
                        end else if (req_num > max_number(variant)) begin
                            resp_r[1] <= fn_read_coef | exc_flag;
                            resp_r[2] <= exc_range;
                            resp_len_r <= len_exc;
                        end else begin
                            resp_r[1] <= fn_read_coef;
                            resp_r[2] <= read_value[31:24];
                            resp_r[3] <= read_value[23:16];
                            resp_r[4] <= read_value[15:8];
                            resp_r[5] <= read_value[7:0];
                            resp_len_r <= len_value;
                        end
                    end else begin
                        // Corrupt, foreign or other-function frames get silence
                        state_r <= st_idle;
                    end
                end
                st_send: begin
                    // Each byte holds until the line layer takes it
                    if (tx_ready) begin
                        idx_r <= idx_r + 3'h1;
                        if (idx_r < resp_len_r) begin
                            tx_crc_r <= tx_crc_nxt;
                        end
                        // Ends tested first: idx_r + 1 would wrap to zero at seven
                        if (idx_r > resp_len_r) begin
                            tx_valid_r <= 1'b0;
                            tx_data_r <= 8'h00;
                            state_r <= st_idle;
                        end else if (idx_r == resp_len_r) begin
                            tx_data_r <= tx_crc_r[7:0];
                        end else if (idx_r + 3'h1 == resp_len_r) begin
                            tx_data_r <= tx_crc_nxt[15:8];
                        end else begin
                            tx_data_r <= resp_r[idx_r + 3'h1];
                        end
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    //****************************************************************
    // Scaling coefficients to the measurement path
    //****************************************************************

    // Registered copy so the arithmetic sees a stable word set each cycle;
    // pressure and calculated channels use gain and offset, temperatures offset only
    always_ff @(posedge clock) begin
        if (!rstn) begin
            scale_r <= '0;
            scale_r.p1_gain <= f_one;
            scale_r.p2_gain <= f_one;
            scale_r.ch0_gain <= f_one;
        end else begin
            scale_r.p1_offset <= coef_mem[num_p1_off];
            scale_r.p1_gain <= coef_mem[num_p1_gain];
            scale_r.p2_offset <= coef_mem[num_p2_off];
            scale_r.p2_gain <= coef_mem[num_p2_gain];
            scale_r.ch0_offset <= coef_mem[num_ch0_off];
            scale_r.ch0_gain <= coef_mem[num_ch0_gain];
            scale_r.aout_offset <= coef_mem[num_aout_off];
            scale_r.aout_gain <= coef_mem[num_aout_gain];
            scale_r.t_offset <= coef_mem[num_t_off];
            scale_r.sensor_one_temperature_offset <= coef_mem[num_sensor_one_temperature_off];
            scale_r.sensor_two_temperature_offset <= coef_mem[num_sensor_two_temperature_off];
            scale_r.sqrt_threshold <= coef_mem[num_sqrt_thr];
        end
    end

    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign initialised = init_r;
    assign scale = scale_r;
endmodule

/* File: read_service_sva.sv */
`timescale 1ns/1ps
//****************************************
// Reply framing checker
//****************************************
module read_service_sva (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] bus_node_id,
    input wire logic rx_frame_end,
    input wire logic tx_ready,
    input wire logic init_ack,
    input logic tx_valid,
    input logic [7:0] tx_data,
    input logic initialised
);
    import coef_pkg::*;
    logic [3:0] idx_r; // Reply bytes taken so far
    // Count handshakes; cleared between replies
    always_ff @(posedge clock) begin
        if (!rstn || !tx_valid) begin
            idx_r <= 4'h0;
        end else if (tx_ready) begin
            idx_r <= idx_r + 4'h1;
        end
    end
    // A stalled byte must not move
    sequence s_stall; tx_valid && !tx_ready; endsequence
    sequence s_held; tx_valid && $stable(tx_data); endsequence
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !tx_valid && !initialised)
        else $error("outputs not cleared by reset");
    a_init_set: assert property (init_ack |=> initialised)
        else $error("init not taken");
    a_init_kept: assert property (initialised |=> initialised)
        else $error("init lost");
    a_byte_held: assert property (s_stall |=> s_held)
        else $error("byte changed during stall");
    a_reply_timing: assert property ($rose(tx_valid) |-> $past(rx_frame_end, 2))
        else $error("reply start not two cycles after frame end");
    a_first_id: assert property ($rose(tx_valid) |->
        tx_data == bus_node_id || tx_data == transparent_id)
        else $error("first reply byte not a node id");
    a_second_fn: assert property (tx_valid && idx_r == 4'h1 |->
        tx_data == fn_read_coef || tx_data == (fn_read_coef | exc_flag))
        else $error("second reply byte not function");
    a_reply_length: assert property ($fell(tx_valid) |-> idx_r == 4'h8 || idx_r == 4'h5)
        else $error("reply length wrong");
endmodule
bind coefficient_read_service read_service_sva chk (.clock(clock), .rstn(rstn),
    .bus_node_id(bus_node_id), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
    .init_ack(init_ack), .tx_valid(tx_valid), .tx_data(tx_data), .initialised(initialised));

/* File: host_model.sv */
`timescale 1ns/1ps
//****************************************
// Bus master on the line side
//****************************************
module host_model
    import coef_pkg::*;
(
    input wire logic clock,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output coef_pkg::byte_t rx_byte,
    output logic rx_frame_end,
    output logic tx_ready
);
    logic [7:0] got[$]; // Reply bytes taken
    initial begin
        rx_byte = '0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b1;
    end
    // Slow mode takes a byte every other cycle
    always @(negedge clock) tx_ready <= slow ? !tx_ready : 1'b1;
    always @(posedge clock) if (tx_valid && tx_ready) got.push_back(tx_data);
    // Reflected CRC16 over n bytes
    function automatic logic [15:0] crc16(input logic [7:0] f[0:9], input int n);
        logic [15:0] c;
        c = crc_init;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ crc_poly : c >> 1;
        end
        return c;
    endfunction
    // Frame of len bytes, CRC high then low; bad spoils the CRC
    task automatic send(input logic [7:0] id, input logic [7:0] num, input int len, input bit bad);
        logic [7:0] f[0:9];
        logic [15:0] c;
        f[0] = id;
        f[1] = fn_read_coef;
        f[2] = num;
        f[3] = 8'h00;
        c = crc16(f, len - 2);
        f[len-2] = c[15:8];
        f[len-1] = c[7:0] ^ {7'h00, bad};
        got.delete();
        for (int i = 0; i < len; i++) begin
            @(negedge clock);
            rx_byte <= {1'b1, f[i]};
        end
        @(negedge clock);
        rx_byte <= {1'b0, ~f[len-1]};
        rx_frame_end <= 1'b1;
        @(negedge clock);
        rx_frame_end <= 1'b0;
        repeat (30) @(negedge clock);
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import coef_pkg::*;
    typedef struct packed {logic [7:0] num; logic [7:0] code; logic [31:0] value;} row_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] node_id = 8'h05; // Own node id
    logic init_ack = 1'b0;
    logic slow = 1'b0;
    logic analog_is_current = 1'b1;
    coef_wr_t host_wr = '0;
    coef_wr_t factory_wr = '0;
    byte_t rx_byte;
    logic rx_frame_end, tx_ready, tx_valid, initialised;
    logic [7:0] tx_data;
    scale_t scale;
    int n_mismatch = 0;
    int checks_done = 0;
    row_t rows[16] = '{'{num_p1_off, 8'h00, 32'h3F000000}, '{num_p1_gain, 8'h00, f_one},
        '{num_p2_off, 8'h00, f_zero}, '{num_p2_gain, 8'h00, f_one},
        '{num_ch0_off, 8'h00, f_zero}, '{num_ch0_gain, 8'h00, f_one},
        '{num_info_lo, 8'h00, 32'h447A0000}, '{num_cal_date, 8'h00, 32'h1F0C07E8},
        '{num_sig_min, 8'h00, f_ma_min}, '{num_sig_max, 8'h00, f_ma_max},
        '{8'h6E, 8'h00, 32'h12345678}, '{num_cond_tc, 8'h00, f_cond_tc},
        '{num_cell, 8'h00, f_one}, '{max_coef_v2, 8'h00, f_zero},
        '{8'h9D, exc_range, 32'h0}, '{8'hFF, exc_range, 32'h0}};
    always #10 clock = ~clock;
    coefficient_read_service DUT (.clock(clock), .rstn(rstn), .bus_node_id(node_id),
        .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
        .init_ack(init_ack), .host_wr(host_wr), .factory_wr(factory_wr),
        .analog_is_current(analog_is_current), .tx_valid(tx_valid), .tx_data(tx_data),
        .initialised(initialised), .scale(scale));
    host_model host (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Build the expected reply here and compare byte by byte
    task automatic expect_reply(input logic [7:0] id, input logic [7:0] code, input logic [31:0] v);
        logic [7:0] f[0:9];
        logic [15:0] c;
        int n;
        f[0] = id;
        f[1] = (code != 8'h00) ? (fn_read_coef | exc_flag) : fn_read_coef;
        {f[2], f[3], f[4], f[5]} = (code != 8'h00) ? {code, 24'h0} : v;
        n = (code != 8'h00) ? 3 : 6;
        c = host.crc16(f, n);
        f[n] = c[15:8];
        f[n+1] = c[7:0];
        check("reply length", n + 2, host.got.size());
        for (int i = 0; i < n + 2 && i < host.got.size(); i++) begin
            check("reply byte", f[i], host.got[i]);
        end
    endtask
    task automatic rd(input logic [7:0] id, input logic [7:0] num, input logic [7:0] code,
        input logic [31:0] v);
        host.send(id, num, 5, 1'b0);
        expect_reply(node_id, code, v); // reply carries the own node id
    endtask
    // One write pulse; released fields show inverted data
    task automatic wr(input bit fac, input logic [7:0] num, input logic [31:0] v);
        @(negedge clock);
        if (fac) factory_wr <= {1'b1, num, v};
        else host_wr <= {1'b1, num, v};
        @(negedge clock);
        factory_wr <= {1'b0, ~num, ~v};
        host_wr <= {1'b0, ~num, ~v};
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (6000) @(posedge clock);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (12) @(negedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check("init after reset", 1'b0, initialised);
        check("reset gain", f_one, scale.ch0_gain);
        rd(node_id, num_p1_gain, exc_uninit, 32'h0);
        init_ack <= 1'b1;
        @(negedge clock);
        init_ack <= 1'b0;
        check("init set", 1'b1, initialised);
        wr(1'b0, num_p1_off, 32'h3F000000);
        wr(1'b1, num_info_lo, 32'h447A0000);
        wr(1'b0, num_info_lo, 32'h0);
        wr(1'b1, num_cal_date, 32'h1F0C07E8);
        wr(1'b0, num_cal_date, 32'h0);
        wr(1'b0, 8'h6E, 32'h12345678);
        wr(1'b0, num_t_off, 32'h40000000);
        foreach (rows[i]) begin
            slow <= i[1];
            rd(i[0] ? transparent_id : node_id, rows[i].num, rows[i].code, rows[i].value);
        end
        rd(node_id, num_p1_off, 8'h00, 32'h3F000000);
        check("scale p1 offset", 32'h3F000000, scale.p1_offset);
        check("scale t offset", 32'h40000000, scale.t_offset);
        wr(1'b1, 8'h5D, 32'h41200000); // pressure at maximum signal
        rd(node_id, 8'h5D, 8'h00, 32'h41200000);
        wr(1'b0, num_aout_off, 32'h3F800000);
        wr(1'b0, num_aout_gain, 32'h40000000);
        wr(1'b0, num_sqrt_thr, 32'h3F000000);
        @(negedge clock);
        check("scale aout gain", 32'h40000000, scale.aout_gain);
        check("scale sqrt threshold", 32'h3F000000, scale.sqrt_threshold);
        rd(node_id, num_aout_off, 8'h00, 32'h3F800000);
        host.send(node_id, num_p1_gain, 4, 1'b0);
        expect_reply(node_id, exc_length, 32'h0);
        host.send(transparent_id, num_p1_gain, 6, 1'b0);
        expect_reply(node_id, exc_length, 32'h0);
        host.send(node_id, num_p1_gain, 5, 1'b1);
        check("bad crc silent", 0, host.got.size());
        host.send(8'h07, num_p1_gain, 5, 1'b0);
        check("foreign id silent", 0, host.got.size());
        analog_is_current <= 1'b0;
        rd(node_id, num_sig_min, 8'h00, f_v_min);
        rd(node_id, num_sig_max, 8'h00, f_v_max);
        rstn <= 1'b0;
        repeat (2) @(negedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check("init after second reset", 1'b0, initialised);
        check("offset after reset", f_zero, scale.p1_offset);
        rd(node_id, num_p1_off, exc_uninit, 32'h0);
        final_report();
    end
endmodule
